// File: hw/mrs_map.svh
// Register map, field positions, reset values and timing counts of the statistics recorder
`ifndef MRS_MAP_SVH
`define MRS_MAP_SVH
`define MRS_CLK_HZ 125000000
`define MRS_FREQ_MIN_HZ 16
`define MRS_FREQ_MAX_HZ 75
`define MRS_PERIOD_MIN_CYC (`MRS_CLK_HZ / `MRS_FREQ_MAX_HZ)
`define MRS_PERIOD_MAX_CYC (`MRS_CLK_HZ / `MRS_FREQ_MIN_HZ)
`define MRS_FREQ_SCALE (48'(`MRS_CLK_HZ) * 48'd100)
`define MRS_FRAME_MS 20
`define MRS_TB_200MS_FRAMES (200 / `MRS_FRAME_MS)
`define MRS_TB_1S_FRAMES (1000 / `MRS_FRAME_MS)
`define MRS_TB_1MIN_FRAMES (60000 / `MRS_FRAME_MS)
`define MRS_DEMAND_MIN_MINUTES 5'h0A
`define MRS_DEMAND_MAX_MINUTES 5'h1E
`define MRS_DEMAND_RST_MINUTES 5'h0A
`define MRS_THD_SCALE 24'h0003E8
`define MRS_DAYS 31
`define MRS_MONTHS 12
`define MRS_RECQ 5
`define MRS_NQ 15
`define MRS_RGN_CTRL 4'h0
`define MRS_RGN_LIVE 4'h1
`define MRS_RGN_HARM 4'h2
`define MRS_RGN_MIN 4'h3
`define MRS_RGN_MAX 4'h4
`define MRS_RGN_MIN_TS 4'h5
`define MRS_RGN_MAX_TS 4'h6
`define MRS_RGN_DAY_MAX 4'h7
`define MRS_RGN_DAY_TS 4'h8
`define MRS_RGN_MON_MAX 4'h9
`define MRS_IDX_CTRL 8'h00
`define MRS_IDX_CMD 8'h01
`define MRS_IDX_STATUS 8'h02
`define MRS_CTRL_DEM_LSB 0
`define MRS_CTRL_TB_LSB 8
`define MRS_CMD_CLR_BIT 0
`define MRS_CMD_DAY_BIT 1
`define MRS_CMD_MON_BIT 2
`endif

// File: hw/mrs_pkg.sv
// Types shared by the statistics recorder and its bench
package mrs_pkg;
  typedef struct packed {
    logic valid;
    logic [1:0] phase;
    logic [3:0] order;
    logic [15:0] mag;
  } mrs_harm_t;
  typedef struct packed {
    logic [15:0] res1;
    logic [15:0] res2;
  } mrs_res_t;
  typedef struct packed {
    logic [17:0] phase1_rms_value;
    logic [17:0] phase2_rms_value;
    logic [17:0] phase3_rms_value;
  } mrs_rms_t;
  typedef struct packed {
    logic [17:0] phase1_demand_value;
    logic [17:0] phase2_demand_value;
    logic [17:0] phase3_demand_value;
  } mrs_demand_t;
  typedef enum logic [2:0] {TB_CYCLE, TB_200MS, TB_1S, TB_1MIN, TB_DEMAND} mrs_timebase_t;
  typedef enum logic [1:0] {S_IDLE, S_ROOT, S_PUB} mrs_state_t;
endpackage : mrs_pkg

// File: hw/mrs_recorder.sv
// Measurement statistics recorder: RMS, harmonics, THD, demand, extremes, day and month records
`timescale 1ns/1ps
`include "mrs_map.svh"
module mrs_recorder (
  input wire logic i_clock, // System clock, 125 MHz
  input wire logic i_sys_rst, // Asynchronous reset, active high
  input wire mrs_pkg::mrs_harm_t i_harm, // One harmonic magnitude word
  input wire logic i_frame_done, // End of a 20 ms frame, never with a word
  input wire mrs_pkg::mrs_res_t i_res, // Residual fundamentals, taken at frame end
  input wire logic i_zero_cross, // Asynchronous zero crossing comparator pin
  input wire logic [31:0] i_time_stamp, // Real time counter
  input wire logic i_day_tick, // Day boundary pulse
  input wire logic i_month_tick, // Month boundary pulse
  input wire logic [13:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Register write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after the strobe
  output mrs_pkg::mrs_rms_t o_rms, // Phase RMS values
  output mrs_pkg::mrs_demand_t o_demand, // Fundamental phase demands
  output logic o_freq_valid // Frequency within measuring range
);
  localparam int NQ = `MRS_NQ;
  localparam int RQ = `MRS_RECQ;

  function automatic logic [17:0] isqrt(input logic [35:0] x);
    logic [17:0] r;
    logic [17:0] t;
    r = '0;
    for (int i = 17; i >= 0; i--) begin
      t = r | (18'h1 << i);
      if ((36'(t) * 36'(t)) <= x) r = t;
    end
    return r;
  endfunction : isqrt

  function automatic logic [17:0] sat_div(input logic [47:0] n, input logic [23:0] d);
    logic [47:0] q;
    q = '0;
    if (d != 24'h0) q = n / 48'(d);
    return (q > 48'h3FFFF) ? 18'h3FFFF : q[17:0];
  endfunction : sat_div

  wire [3:0] rgn = i_addr[13:10];
  wire [7:0] idx = i_addr[9:2];
  wire ctrl_wr = i_wr && rgn == `MRS_RGN_CTRL && idx == `MRS_IDX_CTRL;
  wire cmd_wr = i_wr && rgn == `MRS_RGN_CTRL && idx == `MRS_IDX_CMD;
  wire clr_cmd = cmd_wr && i_wdata[`MRS_CMD_CLR_BIT];
  wire day_rst = cmd_wr && i_wdata[`MRS_CMD_DAY_BIT];
  wire mon_rst = cmd_wr && i_wdata[`MRS_CMD_MON_BIT];

  logic [4:0] dem_min_r;
  mrs_pkg::mrs_timebase_t tb_r;
  // Settings; write access is gated by the operator's password upstream
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dem_min_r <= `MRS_DEMAND_RST_MINUTES;
      tb_r <= mrs_pkg::TB_CYCLE;
    end else if (ctrl_wr) begin
      if (i_wdata[`MRS_CTRL_DEM_LSB +: 5] < `MRS_DEMAND_MIN_MINUTES)
        dem_min_r <= `MRS_DEMAND_MIN_MINUTES;
      else if (i_wdata[`MRS_CTRL_DEM_LSB +: 5] > `MRS_DEMAND_MAX_MINUTES)
        dem_min_r <= `MRS_DEMAND_MAX_MINUTES;
      else
        dem_min_r <= i_wdata[`MRS_CTRL_DEM_LSB +: 5];
      if (i_wdata[`MRS_CTRL_TB_LSB +: 3] <= 3'(mrs_pkg::TB_DEMAND))
        tb_r <= mrs_pkg::mrs_timebase_t'(i_wdata[`MRS_CTRL_TB_LSB +: 3]);
    end
  end

  // Harmonic accumulation per phase
  logic [35:0] acc_all_r [3];
  logic [35:0] acc_hd_r [3];
  logic [17:0] acc_fund_r [3];
  logic [35:0] snap_all_r [3];
  logic [35:0] snap_hd_r [3];
  logic [17:0] snap_fund_r [3];
  logic [15:0] harm_r [3][16];
  mrs_pkg::mrs_res_t res_r;
  wire [35:0] sq = 36'(i_harm.mag) * 36'(i_harm.mag);
  wire word_ok = i_harm.valid && i_harm.phase != 2'h3 && i_harm.order != 4'h0;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int p = 0; p < 3; p++) begin
        acc_all_r[p] <= '0;
        acc_hd_r[p] <= '0;
        acc_fund_r[p] <= '0;
        snap_all_r[p] <= '0;
        snap_hd_r[p] <= '0;
        snap_fund_r[p] <= '0;
        for (int h = 0; h < 16; h++) harm_r[p][h] <= '0;
      end
      res_r <= '0;
    end else if (i_frame_done) begin
      for (int p = 0; p < 3; p++) begin
        snap_all_r[p] <= acc_all_r[p];
        snap_hd_r[p] <= acc_hd_r[p];
        snap_fund_r[p] <= acc_fund_r[p];
        acc_all_r[p] <= '0;
        acc_hd_r[p] <= '0;
      end
      res_r <= i_res;
    end else if (word_ok) begin
      acc_all_r[i_harm.phase] <= acc_all_r[i_harm.phase] + sq;
      if (i_harm.order == 4'h1)
        acc_fund_r[i_harm.phase] <= 18'(i_harm.mag);
      else begin
        acc_hd_r[i_harm.phase] <= acc_hd_r[i_harm.phase] + sq;
        harm_r[i_harm.phase][i_harm.order] <= i_harm.mag;
      end
    end
  end

  // Per-frame roots and ratios, one phase per cycle
  mrs_pkg::mrs_state_t state_r;
  logic [1:0] ph_r;
  logic [17:0] fund_r [3];
  logic [17:0] rms_r [3];
  logic [17:0] thd_r [3];
  wire pub = state_r == mrs_pkg::S_PUB;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= mrs_pkg::S_IDLE;
      ph_r <= '0;
      for (int p = 0; p < 3; p++) begin
        fund_r[p] <= '0;
        rms_r[p] <= '0;
        thd_r[p] <= '0;
      end
    end else begin
      unique case (state_r)
        mrs_pkg::S_IDLE: begin
          ph_r <= '0;
          if (i_frame_done) state_r <= mrs_pkg::S_ROOT;
        end
        mrs_pkg::S_ROOT: begin
          fund_r[ph_r] <= snap_fund_r[ph_r];
          rms_r[ph_r] <= isqrt(snap_all_r[ph_r]);
          thd_r[ph_r] <= sat_div(48'(isqrt(snap_hd_r[ph_r])) * 48'(`MRS_THD_SCALE),
                                 24'(snap_fund_r[ph_r]));
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h2) state_r <= mrs_pkg::S_PUB;
        end
        mrs_pkg::S_PUB: state_r <= mrs_pkg::S_IDLE;
      endcase
    end
  end

  // Frequency from zero crossing period
  logic [2:0] zc_r;
  logic [23:0] per_r;
  logic [17:0] freq_r;
  logic freq_new_r;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      zc_r <= '0;
      per_r <= '0;
      freq_r <= '0;
      freq_new_r <= 1'b0;
      o_freq_valid <= 1'b0;
    end else begin
      zc_r <= {zc_r[1:0], i_zero_cross};
      freq_new_r <= 1'b0;
      if (per_r != 24'hFFFFFF) per_r <= per_r + 24'h1;
      if (zc_r[1] && !zc_r[2]) begin
        per_r <= 24'h1;
        if (per_r >= 24'(`MRS_PERIOD_MIN_CYC) && per_r <= 24'(`MRS_PERIOD_MAX_CYC)) begin
          freq_r <= sat_div(`MRS_FREQ_SCALE, per_r);
          freq_new_r <= 1'b1;
          o_freq_valid <= 1'b1;
        end else
          o_freq_valid <= 1'b0;
      end
    end
  end

  // Demand averaging of fundamental and RMS values
  logic [39:0] dacc_f_r [3];
  logic [39:0] dacc_r_r [3];
  logic [16:0] dcnt_r;
  logic [17:0] dem_f_r [3];
  logic [17:0] dem_r_r [3];
  logic dem_pub_r;
  wire [16:0] dem_win = 17'(dem_min_r) * 17'(`MRS_TB_1MIN_FRAMES);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dcnt_r <= '0;
      dem_pub_r <= 1'b0;
      for (int p = 0; p < 3; p++) begin
        dacc_f_r[p] <= '0;
        dacc_r_r[p] <= '0;
        dem_f_r[p] <= '0;
        dem_r_r[p] <= '0;
      end
    end else begin
      dem_pub_r <= 1'b0;
      if (pub) begin
        if (dcnt_r + 17'h1 >= dem_win) begin
          dcnt_r <= '0;
          dem_pub_r <= 1'b1;
          for (int p = 0; p < 3; p++) begin
            dem_f_r[p] <= sat_div(48'(dacc_f_r[p] + 40'(fund_r[p])), 24'(dem_win));
            dem_r_r[p] <= sat_div(48'(dacc_r_r[p] + 40'(rms_r[p])), 24'(dem_win));
            dacc_f_r[p] <= '0;
            dacc_r_r[p] <= '0;
          end
        end else begin
          dcnt_r <= dcnt_r + 17'h1;
          for (int p = 0; p < 3; p++) begin
            dacc_f_r[p] <= dacc_f_r[p] + 40'(fund_r[p]);
            dacc_r_r[p] <= dacc_r_r[p] + 40'(rms_r[p]);
          end
        end
      end
    end
  end

  // Tracked quantities and their update moments
  logic [17:0] q [NQ];
  logic [NQ-1:0] q_upd;
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      q[p] = fund_r[p];
      q[3 + p] = rms_r[p];
      q[9 + p] = dem_f_r[p];
      q[12 + p] = dem_r_r[p];
    end
    q[6] = 18'(res_r.res1);
    q[7] = 18'(res_r.res2);
    q[8] = freq_r;
    q_upd = {{6{dem_pub_r}}, freq_new_r, {8{pub}}};
  end

  logic [17:0] min_r [NQ];
  logic [17:0] max_r [NQ];
  logic [31:0] min_ts_r [NQ];
  logic [31:0] max_ts_r [NQ];
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NQ; i++) begin
        min_r[i] <= 18'h3FFFF;
        max_r[i] <= '0;
        min_ts_r[i] <= '0;
        max_ts_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NQ; i++) begin
        if (clr_cmd) begin
          min_r[i] <= q_upd[i] ? q[i] : 18'h3FFFF;
          max_r[i] <= q_upd[i] ? q[i] : 18'h0;
          min_ts_r[i] <= q_upd[i] ? i_time_stamp : 32'h0;
          max_ts_r[i] <= q_upd[i] ? i_time_stamp : 32'h0;
        end else if (q_upd[i]) begin
          if (q[i] < min_r[i]) begin
            min_r[i] <= q[i];
            min_ts_r[i] <= i_time_stamp;
          end
          if (q[i] > max_r[i]) begin
            max_r[i] <= q[i];
            max_ts_r[i] <= i_time_stamp;
          end
        end
      end
    end
  end

  // Timebase feed for day and month records: IL1-3, Io1, Io2
  logic [31:0] tacc_r [RQ];
  logic [11:0] tcnt_r;
  logic [17:0] rec_r [RQ];
  logic rec_new_r;
  logic [11:0] tb_n;
  always_comb begin
    unique case (tb_r)
      mrs_pkg::TB_200MS: tb_n = 12'(`MRS_TB_200MS_FRAMES);
      mrs_pkg::TB_1S: tb_n = 12'(`MRS_TB_1S_FRAMES);
      mrs_pkg::TB_1MIN: tb_n = 12'(`MRS_TB_1MIN_FRAMES);
      default: tb_n = 12'h001;
    endcase
  end
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tcnt_r <= '0;
      rec_new_r <= 1'b0;
      for (int k = 0; k < RQ; k++) begin
        tacc_r[k] <= '0;
        rec_r[k] <= '0;
      end
    end else begin
      rec_new_r <= 1'b0;
      if (tb_r == mrs_pkg::TB_DEMAND) begin
        tcnt_r <= '0;
        if (dem_pub_r) begin
          for (int k = 0; k < RQ; k++) rec_r[k] <= q[(k < 3) ? 9 + k : 3 + k];
          rec_new_r <= 1'b1;
        end
      end else if (pub) begin
        if (tcnt_r + 12'h1 >= tb_n) begin
          tcnt_r <= '0;
          rec_new_r <= 1'b1;
          for (int k = 0; k < RQ; k++) begin
            rec_r[k] <= sat_div(48'(tacc_r[k] + 32'(q[(k < 3) ? k : 3 + k])),
                                24'(tb_n));
            tacc_r[k] <= '0;
          end
        end else begin
          tcnt_r <= tcnt_r + 12'h1;
          for (int k = 0; k < RQ; k++)
            tacc_r[k] <= tacc_r[k] + 32'(q[(k < 3) ? k : 3 + k]);
        end
      end
    end
  end

  // Day and month records; the stores are left out of reset so they persist
  logic [17:0] day_cur_r [RQ];
  logic [31:0] day_cur_ts_r [RQ];
  logic [17:0] mon_cur_r [RQ];
  logic [17:0] day_mem [`MRS_DAYS][RQ];
  logic [31:0] day_ts_mem [`MRS_DAYS][RQ];
  logic [17:0] mon_mem [`MRS_MONTHS][RQ];
  logic [4:0] day_ptr_r;
  logic [3:0] mon_ptr_r;
  always_ff @(posedge i_clock) begin
    if (day_rst) begin
      for (int d = 0; d < `MRS_DAYS; d++)
        for (int k = 0; k < RQ; k++) begin
          day_mem[d][k] <= '0;
          day_ts_mem[d][k] <= '0;
        end
    end else if (i_day_tick) begin
      for (int k = 0; k < RQ; k++) begin
        day_mem[day_ptr_r][k] <= day_cur_r[k];
        day_ts_mem[day_ptr_r][k] <= day_cur_ts_r[k];
      end
    end
    if (mon_rst) begin
      for (int m = 0; m < `MRS_MONTHS; m++)
        for (int k = 0; k < RQ; k++) mon_mem[m][k] <= '0;
    end else if (i_month_tick) begin
      for (int k = 0; k < RQ; k++) mon_mem[mon_ptr_r][k] <= mon_cur_r[k];
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      day_ptr_r <= '0;
      mon_ptr_r <= '0;
      for (int k = 0; k < RQ; k++) begin
        day_cur_r[k] <= '0;
        day_cur_ts_r[k] <= '0;
        mon_cur_r[k] <= '0;
      end
    end else begin
      if (day_rst) day_ptr_r <= '0;
      else if (i_day_tick)
        day_ptr_r <= (day_ptr_r == 5'(`MRS_DAYS - 1)) ? 5'h00 : day_ptr_r + 5'h01;
      if (mon_rst) mon_ptr_r <= '0;
      else if (i_month_tick)
        mon_ptr_r <= (mon_ptr_r == 4'(`MRS_MONTHS - 1)) ? 4'h0 : mon_ptr_r + 4'h1;
      for (int k = 0; k < RQ; k++) begin
        if (day_rst || i_day_tick) begin
          day_cur_r[k] <= rec_new_r ? rec_r[k] : 18'h0;
          day_cur_ts_r[k] <= rec_new_r ? i_time_stamp : 32'h0;
        end else if (rec_new_r && rec_r[k] > day_cur_r[k]) begin
          day_cur_r[k] <= rec_r[k];
          day_cur_ts_r[k] <= i_time_stamp;
        end
        if (mon_rst || i_month_tick)
          mon_cur_r[k] <= rec_new_r ? rec_r[k] : 18'h0;
        else if (rec_new_r && rec_r[k] > mon_cur_r[k])
          mon_cur_r[k] <= rec_r[k];
      end
    end
  end

  // Register read port
  wire [4:0] rd_day = idx[7:3];
  wire [2:0] rd_k = idx[2:0];
  wire rd_in_day = rd_day < 5'(`MRS_DAYS) && rd_k < 3'(`MRS_RECQ);
  wire rd_in_mon = idx[7:3] < 5'(`MRS_MONTHS) && rd_k < 3'(`MRS_RECQ);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) o_rdata <= '0;
    else if (i_rd) begin
      o_rdata <= '0;
      unique case (rgn)
        `MRS_RGN_CTRL:
          if (idx == `MRS_IDX_CTRL)
            o_rdata <= {21'h0, 3'(tb_r), 3'h0, dem_min_r};
          else if (idx == `MRS_IDX_STATUS)
            o_rdata <= {12'h0, mon_ptr_r, 3'h0, day_ptr_r, 7'h0, o_freq_valid};
        `MRS_RGN_LIVE:
          if (idx < 8'(NQ)) o_rdata <= 32'(q[idx[3:0]]);
          else if (idx < 8'(NQ + 3)) o_rdata <= 32'(thd_r[2'(idx - 8'(NQ))]);
        `MRS_RGN_HARM:
          if (idx[7:4] < 4'h3) o_rdata <= 32'(harm_r[idx[5:4]][idx[3:0]]);
        `MRS_RGN_MIN: if (idx < 8'(NQ)) o_rdata <= 32'(min_r[idx[3:0]]);
        `MRS_RGN_MAX: if (idx < 8'(NQ)) o_rdata <= 32'(max_r[idx[3:0]]);
        `MRS_RGN_MIN_TS: if (idx < 8'(NQ)) o_rdata <= min_ts_r[idx[3:0]];
        `MRS_RGN_MAX_TS: if (idx < 8'(NQ)) o_rdata <= max_ts_r[idx[3:0]];
        `MRS_RGN_DAY_MAX: if (rd_in_day) o_rdata <= 32'(day_mem[rd_day][rd_k]);
        `MRS_RGN_DAY_TS: if (rd_in_day) o_rdata <= day_ts_mem[rd_day][rd_k];
        `MRS_RGN_MON_MAX: if (rd_in_mon) o_rdata <= 32'(mon_mem[idx[6:3]][rd_k]);
        default: o_rdata <= '0;
      endcase
    end
  end

  assign o_rms = {rms_r[0], rms_r[1], rms_r[2]};
  assign o_demand = {dem_f_r[0], dem_f_r[1], dem_f_r[2]};
endmodule : mrs_recorder

// File: sim/mrs_recorder_asserts.sv
// Port checker of the statistics recorder, bound to its top module
`timescale 1ns/1ps
module mrs_recorder_chk (
  input wire logic i_clock, // System clock
  input wire logic i_sys_rst, // Async reset, active high
  input wire logic i_frame_done, // Frame end pulse
  input wire logic i_zero_cross, // Zero crossing pin
  input wire logic [13:0] i_addr, // Register address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [31:0] o_rdata, // Read data
  input wire mrs_pkg::mrs_rms_t o_rms, // Phase RMS values
  input wire mrs_pkg::mrs_demand_t o_demand, // Phase demands
  input wire logic o_freq_valid // Frequency in range
);
  logic [7:0] since_fd_r;
  logic [7:0] since_zc_r;
  logic zc_q_r;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Saturating age of the last frame end
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      since_fd_r <= 8'hFF;
    end else if (i_frame_done) begin
      since_fd_r <= 8'h00;
    end else if (since_fd_r != 8'hFF) begin
      since_fd_r <= since_fd_r + 8'h01;
    end
  end
  // Saturating age of the last rising zero crossing
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      zc_q_r <= 1'b0;
      since_zc_r <= 8'hFF;
    end else begin
      zc_q_r <= i_zero_cross;
      if (i_zero_cross && !zc_q_r) begin
        since_zc_r <= 8'h00;
      end else if (since_zc_r != 8'hFF) begin
        since_zc_r <= since_zc_r + 8'h01;
      end
    end
  end
  rms_timing_a: assert property ($changed(o_rms) |-> since_fd_r inside {[1:5]})
    else $error("RMS output changed away from a frame end");
  demand_timing_a: assert property ($changed(o_demand) |-> since_fd_r <= 8'h0A)
    else $error("Demand output changed away from a frame end");
  freq_rise_a: assert property ($rose(o_freq_valid) |-> since_zc_r <= 8'h08)
    else $error("Frequency valid rose without a zero crossing");
  rdata_hold_a: assert property ($changed(o_rdata) |-> $past(i_rd))
    else $error("Read data changed without a read");
  unmapped_zero_a: assert property (i_rd && i_addr[13:10] > 4'h9 |=> o_rdata == 32'h0)
    else $error("Unmapped read returned nonzero data");
  ctrl_clamp_a: assert property (i_rd && i_addr == 14'h0000 |=>
    o_rdata[4:0] inside {[5'h0A:5'h1E]} && o_rdata[31:11] == 21'h0)
    else $error("Demand time read outside its range");
  status_ptr_a: assert property (i_rd && i_addr == 14'h0008 |=> o_rdata[0] == $past(o_freq_valid)
    && o_rdata[12:8] < 5'h1F && o_rdata[19:16] < 4'hC)
    else $error("Status read inconsistent");
  rms_live_a: assert property (i_rd && i_addr == 14'h040C |=>
    o_rdata == {14'h0, $past(o_rms.phase1_rms_value)})
    else $error("Live RMS read differs from the RMS output");
  demand_live_a: assert property (i_rd && i_addr == 14'h0424 |=>
    o_rdata == {14'h0, $past(o_demand.phase1_demand_value)})
    else $error("Live demand read differs from the demand output");
  clear_max_a: assert property (i_wr && i_addr == 14'h0004 && i_wdata[0] && since_fd_r > 8'h0A
    ##2 i_rd && i_addr == 14'h1000 |=> o_rdata == 32'h0)
    else $error("Maximum not cleared by the clear command");
endmodule : mrs_recorder_chk
bind mrs_recorder mrs_recorder_chk u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_frame_done(i_frame_done), .i_zero_cross(i_zero_cross), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rms(o_rms),
  .o_demand(o_demand), .o_freq_valid(o_freq_valid));

// File: sim/testbench.sv
// Self-checking bench of the statistics recorder
`timescale 1ns/1ps
module testbench;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  mrs_pkg::mrs_harm_t i_harm = '0;
  logic i_frame_done = 1'b0;
  mrs_pkg::mrs_res_t i_res = '0;
  logic i_zero_cross = 1'b0;
  logic [31:0] i_time_stamp = 32'h0;
  logic i_day_tick = 1'b0;
  logic i_month_tick = 1'b0;
  logic [13:0] i_addr = 14'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  mrs_pkg::mrs_rms_t o_rms;
  mrs_pkg::mrs_demand_t o_demand;
  logic o_freq_valid;
  int n_fail = 0;
  int checks = 0;
  always #4 i_clock = ~i_clock;
  mrs_recorder dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_harm(i_harm),
    .i_frame_done(i_frame_done), .i_res(i_res), .i_zero_cross(i_zero_cross),
    .i_time_stamp(i_time_stamp), .i_day_tick(i_day_tick), .i_month_tick(i_month_tick),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_rms(o_rms), .o_demand(o_demand), .o_freq_valid(o_freq_valid));
  task automatic complete_run;
    $display("TB: checks %0d, failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [13:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rc
  task automatic hw(input logic [1:0] p, input logic [3:0] o, input logic [15:0] m);
    @(posedge i_clock);
    i_harm <= {1'b1, p, o, m};
    @(posedge i_clock);
    i_harm.valid <= 1'b0;
  endtask : hw
  // One frame: phase 1 fundamental f0 with fixed harmonics, phase 2 is 3 and 4, phase 3 empty
  task automatic load(input logic [15:0] f0, input logic [31:0] ts);
    hw(2'h0, 4'h1, f0);
    hw(2'h0, 4'h3, 16'h000A);
    hw(2'h0, 4'h7, 16'h0003);
    hw(2'h0, 4'hB, 16'h0008);
    hw(2'h1, 4'h1, 16'h0003);
    hw(2'h1, 4'h2, 16'h0004);
    @(posedge i_clock);
    i_time_stamp <= ts;
    i_frame_done <= 1'b1;
    @(posedge i_clock);
    i_frame_done <= 1'b0;
    repeat (12) @(posedge i_clock);
    #1;
  endtask : load
  initial begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    chk({29'h0, |o_rms, |o_demand, o_freq_valid}, 32'h0);
    rc(14'h0000, 32'h0000000A);
    rc(14'h1000, 32'h0);
    rc(14'h0C00, 32'h0003FFFF);
    wr(14'h0000, 32'h0);
    rc(14'h0000, 32'h0000000A);
    wr(14'h0000, 32'h0000001F);
    rc(14'h0000, 32'h0000001E);
    for (int t = 0; t < 5; t++) begin
      wr(14'h0000, {21'h0, 3'(t), 8'h14});
      rc(14'h0000, {21'h0, 3'(t), 8'h14});
    end
    wr(14'h0000, 32'h0000000A);
    wr(14'h3C00, 32'hFFFFFFFF);
    rc(14'h3C00, 32'h0);
    i_res <= {16'h0040, 16'h0020};
    load(16'h0064, 32'h00000011);
    chk(32'(o_rms.phase1_rms_value), 32'h64);
    chk(32'(o_rms.phase2_rms_value), 32'h5);
    chk(32'(o_rms.phase3_rms_value), 32'h0);
    rc(14'h0400, 32'h64);
    rc(14'h040C, 32'h64);
    rc(14'h0424, 32'h0);
    rc(14'h043C, 32'h82);
    rc(14'h0440, 32'h535);
    rc(14'h080C, 32'hA);
    rc(14'h0848, 32'h4);
    rc(14'h0418, 32'h40);
    load(16'h0032, 32'h00000022);
    chk(32'(o_rms.phase1_rms_value), 32'h33);
    rc(14'h0C00, 32'h32);
    rc(14'h1000, 32'h64);
    rc(14'h1800, 32'h11);
    rc(14'h1400, 32'h22);
    rc(14'h101C, 32'h20);
    @(posedge i_clock);
    i_day_tick <= 1'b1;
    @(posedge i_clock);
    i_day_tick <= 1'b0;
    rc(14'h0008, 32'h00000100);
    rc(14'h1C00, 32'h64);
    rc(14'h1C0C, 32'h40);
    @(posedge i_clock);
    i_month_tick <= 1'b1;
    @(posedge i_clock);
    i_month_tick <= 1'b0;
    rc(14'h0008, 32'h00010100);
    rc(14'h2400, 32'h64);
    wr(14'h0004, 32'h2);
    rc(14'h0008, 32'h00010000);
    rc(14'h1C00, 32'h0);
    wr(14'h0004, 32'h4);
    rc(14'h0008, 32'h0);
    rc(14'h2400, 32'h0);
    wr(14'h0004, 32'h1);
    rc(14'h1000, 32'h0);
    rc(14'h0C00, 32'h0003FFFF);
    rc(14'h1018, 32'h0);
    load(16'h0046, 32'h00000033);
    rc(14'h1000, 32'h46);
    rc(14'h0C00, 32'h46);
    // Crossings far faster than 75 Hz must not count as a valid frequency
    for (int k = 0; k < 8; k++) begin
      repeat (50) @(posedge i_clock);
      i_zero_cross <= ~i_zero_cross;
    end
    repeat (10) @(posedge i_clock);
    #1;
    chk({31'h0, o_freq_valid}, 32'h0);
    wr(14'h0000, 32'h0000001E);
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    chk({30'h0, |o_rms, |o_demand}, 32'h0);
    rc(14'h0000, 32'h0000000A);
    complete_run;
  end
endmodule : testbench
